// [logic/vclr_regs.sv]
`timescale 1ns/1ps
module vclr_regs
    import vclr_pkg::*;
(
    input  wire logic        clk,                        // 25 MHz system clock
    input  wire logic        rst,                        // Power-on reset, sync
    input  wire logic        cmd_wr,                     // Write strobe, one cycle
    input  wire logic        cmd_rd,                     // Read strobe, one cycle
    input  wire logic [7:0]  cmd_code,                   // Command code
    input  wire logic [15:0] cmd_wdata,                  // Write data
    output logic      [15:0] rsp_rdata_q,                // Read data
    output logic             rsp_valid_q,                // Read data valid
    output logic             rsp_unsupported_q,          // Bad code or write to RO
    input  wire logic [2:0]  ss_rate_pin,                // Soft-start rate pin
    input  wire logic [15:0] max_current_setting_pin,    // Max current in A
    input  wire logic        startup_done,               // Startup pulse
    input  wire logic [7:0]  vout_status_flags,          // Output voltage flags
    input  wire logic [6:0]  iout_status_flags,          // Output current flags 6:0
    input  wire logic [7:0]  cml_status_flags,           // Communication flags
    input  wire logic        ovp_abs_event,              // Absolute overvoltage
    input  wire logic        ovp_event,                  // Normal overvoltage
    input  wire logic        uvp_event,                  // Undervoltage
    input  wire logic        ocp_event,                  // Overcurrent
    input  wire logic        otp_event,                  // Overtemperature
    input  wire logic        aux_voltage_monitor_event,  // Aux monitor limit
    input  wire logic        ocp_shutdown,               // Off due to overcurrent
    input  wire logic        iout_fault_clear,           // Clear overcurrent flag
    output logic             alert_q,                    // Alert request, high
    output logic      [7:0]  slew_rate_eighths_q,        // Slew in 0.125 mV/us
    output logic             lock_active_q,              // Lock state
    output logic             iout_oc_fault_q,            // Overcurrent fault flag
    output logic             soft_reset_pulse_q          // Soft reset to device
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0]  ss_sync;
    logic [15:0] max_current_setting_pin_sync;

    vclr_pin_sync #(.W(3), .RST_VAL(VCLR_SLEW_RST)) u_ss_sync (
        .clk    (clk),
        .rst    (rst),
        .pin_in (ss_rate_pin),
        .val_q  (ss_sync)
    );

    vclr_pin_sync #(.W(16), .RST_VAL(VCLR_MAX_CURRENT_SETTING_PIN_RST)) u_max_current_setting_pin_sync (
        .clk    (clk),
        .rst    (rst),
        .pin_in (max_current_setting_pin),
        .val_q  (max_current_setting_pin_sync)
    );

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic        lock_q;
    logic        lock_d;
    logic [2:0]  slew_q;
    logic [2:0]  slew_d;
    logic [7:0]  mask_q;
    logic [7:0]  mask_d;
    logic        oc_d;
    logic        soft_rst;
    logic        wr_ok;
    logic        hit_lr;
    logic        hit_slew;
    logic        hit_max_current_setting_pin;
    logic        hit_mask;

    // Command decode
    always_comb begin
        hit_lr   = (cmd_code == VCLR_LOCK_RESET_OFS);
        hit_slew = (cmd_code == VCLR_SLEW_OFS);
        hit_max_current_setting_pin = (cmd_code == VCLR_MAX_CURRENT_SETTING_PIN_OFS);
        hit_mask = (cmd_code == VCLR_MASK_OFS);
        wr_ok    = cmd_wr & ~lock_q;
        soft_rst = wr_ok & hit_lr & cmd_wdata[VCLR_RESET_BIT];
    end

    // Next values; soft reset outranks a lock set in the same write
    always_comb begin
        lock_d = lock_q;
        slew_d = slew_q;
        mask_d = mask_q;
        if (soft_rst) begin
            lock_d = VCLR_LOCK_RST;
            slew_d = VCLR_SLEW_RST;
            mask_d = VCLR_MASK_RST;
        end else begin
            if (wr_ok && hit_lr) begin
                lock_d = cmd_wdata[VCLR_LOCK_BIT];
            end
            if (startup_done && !lock_q) begin
                slew_d = ss_sync;
            end
            // A host write in the same cycle wins over the startup load
            if (wr_ok && hit_slew) begin
                slew_d = cmd_wdata[VCLR_SLEW_MSB:VCLR_SLEW_LSB];
            end
            if (wr_ok && hit_mask) begin
                mask_d = cmd_wdata[7:0];
            end
        end
        oc_d = ocp_shutdown | (iout_oc_fault_q & ~iout_fault_clear & ~soft_rst);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lock_q             <= VCLR_LOCK_RST;
            slew_q             <= VCLR_SLEW_RST;
            mask_q             <= VCLR_MASK_RST;
            iout_oc_fault_q    <= 1'b0;
            soft_reset_pulse_q <= 1'b0;
        end else begin
            lock_q             <= lock_d;
            slew_q             <= slew_d;
            mask_q             <= mask_d;
            iout_oc_fault_q    <= oc_d;
            soft_reset_pulse_q <= soft_rst;
        end
    end

    // ------------------------------------------------------------
    // Alert source gating
    // ------------------------------------------------------------
    logic [7:0] src_active;

    vclr_src_gate #(.W(8)) u_gate_vout (
        .flags    (vout_status_flags),
        .mask_bit (mask_q[VCLR_MASK_VOUT_BIT]),
        .active   (src_active[7])
    );
    vclr_src_gate #(.W(8)) u_gate_iout (
        .flags    ({iout_oc_fault_q, iout_status_flags}),  // Sticky flag is bit 7
        .mask_bit (mask_q[VCLR_MASK_IOUT_BIT]),
        .active   (src_active[6])
    );
    vclr_src_gate #(.W(2)) u_gate_ov (
        .flags    ({ovp_abs_event, ovp_event}),
        .mask_bit (mask_q[VCLR_MASK_OV_BIT]),
        .active   (src_active[5])
    );
    vclr_src_gate #(.W(1)) u_gate_uv (
        .flags    (uvp_event),
        .mask_bit (mask_q[VCLR_MASK_UV_BIT]),
        .active   (src_active[4])
    );
    vclr_src_gate #(.W(1)) u_gate_oc (
        .flags    (ocp_event),
        .mask_bit (mask_q[VCLR_MASK_OC_BIT]),
        .active   (src_active[3])
    );
    vclr_src_gate #(.W(1)) u_gate_ot (
        .flags    (otp_event),
        .mask_bit (mask_q[VCLR_MASK_OT_BIT]),
        .active   (src_active[2])
    );
    vclr_src_gate #(.W(8)) u_gate_cml (
        .flags    (cml_status_flags),
        .mask_bit (mask_q[VCLR_MASK_CML_BIT]),
        .active   (src_active[1])
    );
    vclr_src_gate #(.W(1)) u_gate_aux (
        .flags    (aux_voltage_monitor_event),
        .mask_bit (mask_q[VCLR_MASK_AUX_BIT]),
        .active   (src_active[0])
    );

    // ------------------------------------------------------------
    // Outputs: alert, slew decode, read port
    // ------------------------------------------------------------
    logic        alert_d;
    logic [7:0]  slew_rate_d;
    logic [15:0] rdata_d;
    logic        unsup_d;

    always_comb begin
        alert_d     = |src_active;
        slew_rate_d = VCLR_SLEW_UNIT << slew_q;
        rdata_d     = VCLR_RDATA_RST;
        unsup_d     = 1'b0;
        if (hit_lr) begin
            rdata_d[VCLR_LOCK_BIT] = lock_q;   // Reset bit always reads zero
        end else if (hit_slew) begin
            rdata_d[VCLR_SLEW_MSB:VCLR_SLEW_LSB] = slew_q;
        end else if (hit_max_current_setting_pin) begin
            rdata_d = max_current_setting_pin_sync;
            unsup_d = cmd_wr;
        end else if (hit_mask) begin
            rdata_d[7:0] = mask_q;
        end else begin
            unsup_d = cmd_wr | cmd_rd;
        end
    end

    // Read data holds until the next read; valid lasts one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            alert_q             <= 1'b0;
            slew_rate_eighths_q <= VCLR_SLEW_RATE_RST;
            lock_active_q       <= VCLR_LOCK_RST;
            rsp_rdata_q         <= VCLR_RDATA_RST;
            rsp_valid_q         <= 1'b0;
            rsp_unsupported_q   <= 1'b0;
        end else begin
            alert_q             <= alert_d;
            slew_rate_eighths_q <= slew_rate_d;
            lock_active_q       <= lock_d;
            rsp_rdata_q         <= cmd_rd ? rdata_d : rsp_rdata_q;
            rsp_valid_q         <= cmd_rd;
            rsp_unsupported_q   <= unsup_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence unlocked_slew_write_s;
        cmd_wr && !lock_q && hit_slew;
    endsequence
    sequence startup_only_s;
        startup_done && !lock_q && !(cmd_wr && (hit_slew || hit_lr));
    endsequence
    soft_reset_clear_a: assert property (
        @(posedge clk) disable iff (rst)
        (cmd_wr && !lock_q && hit_lr && cmd_wdata[VCLR_RESET_BIT])
        |=> (slew_q == VCLR_SLEW_RST) && (mask_q == VCLR_MASK_RST) && !lock_q
            && soft_reset_pulse_q)
        else $error("soft reset did not restore defaults");
    locked_reset_ign_a: assert property (
        @(posedge clk) disable iff (rst)
        (lock_q && cmd_wr && hit_lr && !startup_done)
        |=> $stable(slew_q) && $stable(mask_q) && lock_q && !soft_reset_pulse_q)
        else $error("soft reset acted while locked");
    lock_set_a: assert property (
        @(posedge clk) disable iff (rst)
        (cmd_wr && !lock_q && hit_lr && cmd_wdata[VCLR_LOCK_BIT]
            && !cmd_wdata[VCLR_RESET_BIT])
        |=> lock_q ##1 lock_active_q)
        else $error("lock bit write did not lock");
    lock_persist_a: assert property (
        @(posedge clk) disable iff (rst)
        lock_q |=> lock_q [*4])
        else $error("lock released without power cycle");
    locked_mask_a: assert property (
        @(posedge clk) disable iff (rst)
        (lock_q && cmd_wr && hit_mask) |=> $stable(mask_q))
        else $error("mask changed while locked");
    startup_load_a: assert property (
        @(posedge clk) disable iff (rst)
        startup_only_s |=> (slew_q == $past(ss_sync)))
        else $error("startup did not load slew from pin");
    slew_decode_a: assert property (
        @(posedge clk) disable iff (rst)
        unlocked_slew_write_s
        |=> ##1 (slew_rate_eighths_q == (VCLR_SLEW_UNIT << $past(cmd_wdata[7:5], 2))))
        else $error("slew code decoded wrongly");
    slew_4mv_a: assert property (
        @(posedge clk) disable iff (rst)
        (slew_q == 3'h5) |=> (slew_rate_eighths_q == VCLR_SLEW_4MV))
        else $error("code 101 not 4 mV/us");
    max_current_setting_pin_read_a: assert property (
        @(posedge clk) disable iff (rst)
        (cmd_rd && hit_max_current_setting_pin) |=> rsp_valid_q && (rsp_rdata_q == $past(max_current_setting_pin_sync)))
        else $error("max current readback wrong");
    vout_mask_a: assert property (
        @(posedge clk) disable iff (rst)
        mask_q[VCLR_MASK_VOUT_BIT] |-> !src_active[7])
        else $error("masked voltage flags reach alert");
    iout_mask_a: assert property (
        @(posedge clk) disable iff (rst)
        mask_q[VCLR_MASK_IOUT_BIT] |-> !src_active[6])
        else $error("masked current flags reach alert");
    ov_mask_a: assert property (
        @(posedge clk) disable iff (rst)
        (mask_q[VCLR_MASK_OV_BIT] && (src_active & 8'hdf) == 8'h00) |=> !alert_q)
        else $error("masked overvoltage raised alert");
    oc_mask_a: assert property (
        @(posedge clk) disable iff (rst)
        (ocp_event && !mask_q[VCLR_MASK_OC_BIT]) |=> alert_q)
        else $error("unmasked overcurrent missed alert");
    cml_mask_a: assert property (
        @(posedge clk) disable iff (rst)
        mask_q[VCLR_MASK_CML_BIT] |-> !src_active[1])
        else $error("masked comm faults reach alert");
    oc_flag_set_a: assert property (
        @(posedge clk) disable iff (rst)
        ocp_shutdown |=> iout_oc_fault_q)
        else $error("overcurrent shutdown flag not set");
    alert_follow_a: assert property (
        @(posedge clk) disable iff (rst)
        (|src_active) |=> alert_q)
        else $error("active source missed alert");

endmodule

// [logic/vclr_pkg.sv]
package vclr_pkg;

    // ------------------------------------------------------------
    // Command codes of the vendor register set
    // ------------------------------------------------------------
    localparam logic [7:0]  VCLR_LOCK_RESET_OFS = 8'hd0;
    localparam logic [7:0]  VCLR_SLEW_OFS       = 8'hd6;
    localparam logic [7:0]  VCLR_MAX_CURRENT_SETTING_PIN_OFS       = 8'hdd;
    localparam logic [7:0]  VCLR_MASK_OFS       = 8'hf9;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          VCLR_LOCK_BIT       = 0;
    localparam int          VCLR_RESET_BIT      = 1;
    localparam int          VCLR_SLEW_MSB       = 7;
    localparam int          VCLR_SLEW_LSB       = 5;
    localparam int          VCLR_MASK_VOUT_BIT  = 7;
    localparam int          VCLR_MASK_IOUT_BIT  = 6;
    localparam int          VCLR_MASK_OV_BIT    = 5;
    localparam int          VCLR_MASK_UV_BIT    = 4;
    localparam int          VCLR_MASK_OC_BIT    = 3;
    localparam int          VCLR_MASK_OT_BIT    = 2;
    localparam int          VCLR_MASK_CML_BIT   = 1;
    localparam int          VCLR_MASK_AUX_BIT   = 0;
    localparam int          VCLR_IOUT_OC_BIT    = 7;

    // ------------------------------------------------------------
    // Values after reset and decode constants
    // ------------------------------------------------------------
    localparam logic        VCLR_LOCK_RST       = 1'b0;
    localparam logic [2:0]  VCLR_SLEW_RST       = 3'h0;
    localparam logic [15:0] VCLR_MAX_CURRENT_SETTING_PIN_RST       = 16'h0000;
    localparam logic [7:0]  VCLR_MASK_RST       = 8'h00;
    localparam logic [15:0] VCLR_RDATA_RST      = 16'h0000;
    localparam logic [7:0]  VCLR_SLEW_UNIT      = 8'h01;  // 0.125 mV/us per count
    localparam logic [7:0]  VCLR_SLEW_RATE_RST  = 8'h01;
    localparam logic [7:0]  VCLR_SLEW_4MV       = 8'h20;
    localparam int          VCLR_SYNC_STAGES    = 3;

endpackage

// [logic/vclr_pin_sync.sv]
`timescale 1ns/1ps
module vclr_pin_sync
    import vclr_pkg::*;
#(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,     // System clock
    input  wire logic         rst,     // Synchronous reset
    input  wire logic [W-1:0] pin_in,  // Asynchronous pin level
    output logic      [W-1:0] val_q    // Settled level
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] val_d;

    // ------------------------------------------------------------
    // Accept only once stages two and three agree
    // ------------------------------------------------------------
    always_comb begin
        val_d = (s2_q == s3_q) ? s3_q : val_q;
    end

    // First stage feeds the second only, to contain metastability
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q  <= RST_VAL;
            s2_q  <= RST_VAL;
            s3_q  <= RST_VAL;
            val_q <= RST_VAL;
        end else begin
            s1_q  <= pin_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            val_q <= val_d;
        end
    end

endmodule

// [logic/vclr_src_gate.sv]
`timescale 1ns/1ps
module vclr_src_gate
    import vclr_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic [W-1:0] flags,     // Fault flags of one source group
    input  wire logic         mask_bit,  // Suppress this group when high
    output logic              active     // Group may raise the alert
);

    // A masked group never reaches the alert
    always_comb begin
        active = (|flags) & ~mask_bit;
    end

endmodule

// [verification/vclr_host_model.sv]
`timescale 1ns/1ps
module vclr_host_model
    import vclr_pkg::*;
(
    input  wire logic        clk,       // System clock
    input  wire logic [15:0] rdata,     // Read data from device
    input  wire logic        valid,     // Read data valid
    input  wire logic        unsup,     // Unsupported flag
    output logic             cmd_wr,    // Write strobe
    output logic             cmd_rd,    // Read strobe
    output logic      [7:0]  cmd_code,  // Command code
    output logic      [15:0] cmd_wdata  // Write data
);
    // Idle bus at time zero
    initial begin
        cmd_wr    = 1'b0;
        cmd_rd    = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // One transfer: strobe for one edge, then released lines show stale inverse
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        output logic [15:0] rd_data, output logic bad);
        @(posedge clk);
        cmd_wr    <= wr;
        cmd_rd    <= ~wr;
        cmd_code  <= code;
        cmd_wdata <= data;
        @(posedge clk);
        cmd_wr    <= 1'b0;
        cmd_rd    <= 1'b0;
        cmd_code  <= ~code;
        cmd_wdata <= ~data;
        #1;
        bad = unsup;
        // Bounded wait, answer must follow a read within three more cycles
        for (int i = 0; i < 3 && !wr && valid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        rd_data = rdata;
    endtask
endmodule

// [verification/vclr_regs_tb.sv]
`timescale 1ns/1ps
module vclr_regs_tb
    import vclr_pkg::*;
;
    logic clk, rst, cmd_wr, cmd_rd, startup_done, ocp_shutdown, iout_fault_clear;
    logic [7:0] cmd_code, vout_status_flags, cml_status_flags, slew_rate_eighths_q;
    logic [15:0] cmd_wdata, rsp_rdata_q, max_current_setting_pin;
    logic [6:0] iout_status_flags;
    logic [2:0] ss_rate_pin;
    logic [8:0] src_q;
    logic rsp_valid_q, rsp_unsupported_q, alert_q, lock_active_q, iout_oc_fault_q;
    logic soft_reset_pulse_q, ovp_abs_event, ovp_event, uvp_event, ocp_event, otp_event;
    logic aux_voltage_monitor_event, last_bad;
    int   fail_count, samples_checked, cyc;

    // Fault sources, one per mask group; bit 8 is the second overvoltage detector
    assign vout_status_flags         = src_q[7] ? 8'h10 : 8'h00;
    assign iout_status_flags         = src_q[6] ? 7'h01 : 7'h00;
    assign cml_status_flags          = src_q[1] ? 8'h02 : 8'h00;
    assign ovp_abs_event             = src_q[5];
    assign ovp_event                 = src_q[8];
    assign uvp_event                 = src_q[4];
    assign ocp_event                 = src_q[3];
    assign otp_event                 = src_q[2];
    assign aux_voltage_monitor_event = src_q[0];

    vclr_regs u_dut (.clk, .rst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .rsp_rdata_q,
        .rsp_valid_q, .rsp_unsupported_q, .ss_rate_pin, .max_current_setting_pin,
        .startup_done, .vout_status_flags, .iout_status_flags, .cml_status_flags,
        .ovp_abs_event, .ovp_event, .uvp_event, .ocp_event, .otp_event,
        .aux_voltage_monitor_event, .ocp_shutdown, .iout_fault_clear, .alert_q,
        .slew_rate_eighths_q, .lock_active_q, .iout_oc_fault_q, .soft_reset_pulse_q);

    vclr_host_model u_host (.clk(clk), .rdata(rsp_rdata_q), .valid(rsp_valid_q),
        .unsup(rsp_unsupported_q), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

    // Clock and hang guard; ceiling is far above the few hundred cycles used
    initial clk = 1'b0;
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        logic [15:0] x;
        u_host.xfer(1'b1, c, d, x, last_bad);
    endtask

    task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] x;
        u_host.xfer(1'b0, c, 16'h0000, x, last_bad);
        check(rsp_valid_q, 16'h0001);
        check(x, e);
    endtask

    task automatic pulse_startup();
        @(posedge clk);
        startup_done <= 1'b1;
        @(posedge clk);
        startup_done <= 1'b0;
        idle(3);
    endtask

    // Main sequence
    initial begin
        {rst, startup_done, ocp_shutdown, iout_fault_clear} = 4'h8;
        src_q = 9'h000;
        ss_rate_pin = 3'h5;
        max_current_setting_pin = 16'h0123;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        idle(8);
        rd_chk(VCLR_LOCK_RESET_OFS, 16'h0000);
        rd_chk(VCLR_SLEW_OFS, 16'h0000);
        rd_chk(VCLR_MASK_OFS, 16'h0000);
        check(slew_rate_eighths_q, 16'h0001);
        rd_chk(8'h55, 16'h0000);
        check(last_bad, 16'h0001);
        rd_chk(VCLR_MAX_CURRENT_SETTING_PIN_OFS, 16'h0123);
        wr(VCLR_MAX_CURRENT_SETTING_PIN_OFS, 16'hffff);
        check(last_bad, 16'h0001);
        rd_chk(VCLR_MAX_CURRENT_SETTING_PIN_OFS, 16'h0123);
        pulse_startup();
        rd_chk(VCLR_SLEW_OFS, 16'h00a0);
        // Host rewrites every slew code after startup
        for (int c = 0; c < 8; c++) begin
            wr(VCLR_SLEW_OFS, 16'(c << 5));
            rd_chk(VCLR_SLEW_OFS, 16'(c << 5));
            idle(2);
            check(slew_rate_eighths_q, 16'h0001 << c);
        end
        // Each source alone: unmasked, own bit masked, all other bits masked
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            src_q <= 9'h001 << i;
            wr(VCLR_MASK_OFS, 16'h0000);
            idle(3);
            check(alert_q, 16'h0001);
            wr(VCLR_MASK_OFS, 16'h0001 << ((i == 8) ? 5 : i));
            idle(3);
            check(alert_q, 16'h0000);
            wr(VCLR_MASK_OFS, ~(16'h0001 << ((i == 8) ? 5 : i)) & 16'h00ff);
            idle(3);
            check(alert_q, 16'h0001);
        end
        @(posedge clk);
        src_q <= 9'h000;
        wr(VCLR_MASK_OFS, 16'h0000);
        @(posedge clk);
        ocp_shutdown <= 1'b1;
        @(posedge clk);
        ocp_shutdown <= 1'b0;
        idle(2);
        check(iout_oc_fault_q, 16'h0001);
        check(alert_q, 16'h0001);
        wr(VCLR_MASK_OFS, 16'h0040);
        idle(3);
        check(alert_q, 16'h0000);
        @(posedge clk);
        iout_fault_clear <= 1'b1;
        @(posedge clk);
        iout_fault_clear <= 1'b0;
        idle(2);
        check(iout_oc_fault_q, 16'h0000);
        wr(VCLR_SLEW_OFS, 16'h0060);
        wr(VCLR_MASK_OFS, 16'h000f);
        wr(VCLR_LOCK_RESET_OFS, 16'h0002);
        check(soft_reset_pulse_q, 16'h0001);
        rd_chk(VCLR_SLEW_OFS, 16'h0000);
        rd_chk(VCLR_MASK_OFS, 16'h0000);
        rd_chk(VCLR_LOCK_RESET_OFS, 16'h0000);
        check(slew_rate_eighths_q, 16'h0001);
        wr(VCLR_SLEW_OFS, 16'h0040);
        wr(VCLR_MASK_OFS, 16'h0001);
        wr(VCLR_LOCK_RESET_OFS, 16'h0001);
        idle(1);
        check(lock_active_q, 16'h0001);
        wr(VCLR_SLEW_OFS, 16'h00e0);
        wr(VCLR_MASK_OFS, 16'h00ff);
        wr(VCLR_LOCK_RESET_OFS, 16'h0002);
        check(soft_reset_pulse_q, 16'h0000);
        wr(VCLR_LOCK_RESET_OFS, 16'h0000);
        pulse_startup();
        rd_chk(VCLR_SLEW_OFS, 16'h0040);
        rd_chk(VCLR_MASK_OFS, 16'h0001);
        rd_chk(VCLR_LOCK_RESET_OFS, 16'h0001);
        check(lock_active_q, 16'h0001);
        // Power cycle is the only way out of the lock
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        idle(1);
        check(lock_active_q, 16'h0000);
        rd_chk(VCLR_LOCK_RESET_OFS, 16'h0000);
        close_out();
    end
endmodule
